// ### design/rcs_ref_select.sv
// Reference clock selector with automatic failover, shutdown pin and PLL divider decode.
// Notes on behaviour
// - Primary-source bit 0 makes the crystal-or-reference input primary, 1 makes the second clock input primary.
// - The input that is not primary is the secondary, a backup used when the primary goes missing.
// - With the upper switchover-mode bit at 0 the input-select pin chooses between primary and secondary.
// - Switching is not aligned to any phase relation between the two references.
// - The shutdown pin holds the reference clock output low, its sense chosen by the polarity bit at 0x02, active low by default.
// - PLLs zero to two take dividers 1 to 127 and power down when their divider is zero.
// - PLL zero multiplies by 2N+A+1 when A is nonzero and by 2N when A is zero.
// - PLLs one to three use the feedback value itself as multiplier.
// - In automatic mode with the crystal-or-reference input as primary, the secondary is taken after two secondary cycles without a primary transition.
// - Automatic mode reverts to the primary as soon as it is present again.
// - Manual switching produces no glitch on the selected reference.
module rcs_ref_select (
    input  wire logic                             core_clk_i,
    input  wire logic                             rst_i,
    input  wire logic                             ce_i,
    input  wire logic                             crystal_or_ref_input_i,
    input  wire logic                             second_clock_input_i,
    input  wire logic                             input_select_pin_i,
    input  wire logic                             shutdown_output_enable_pin_i,
    input  wire logic [7:0]                       addr_i,
    input  wire logic [7:0]                       wdata_i,
    input  wire logic                             wr_i,
    input  wire logic                             rd_i,
    output logic      [7:0]                       rdata_o,
    output logic                                  ref_clk_o,
    output logic                                  active_src_o,
    output logic                                  primary_missing_o,
    output logic                                  shutdown_o,
    output logic      [rcs_pkg::NUM_PLL-1:0]      pll_pd_o,
    output logic      [rcs_pkg::NUM_PLL*14-1:0]   pll_mult_o
);
    import rcs_pkg::*;

    // ------------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------------
    function automatic logic [13:0] mult_calc(input logic is_frac, input logic [11:0] n, input logic [3:0] a);
        logic [13:0] twice_n;
        twice_n = {1'b0, n, 1'b0};
        if (!is_frac) begin
            mult_calc = {2'b00, n};
        end else begin
            mult_calc = twice_n + ((a != 4'h0) ? {10'h000, a} + 14'h0001 : 14'h0000);
        end
    endfunction : mult_calc

    function automatic logic pll_hit(input logic [7:0] addr, input int idx, input logic [1:0] ofs);
        pll_hit = (addr == ADDR_PLL_BASE + 8'(idx) * ADDR_PLL_STRIDE + {6'h00, ofs});
    endfunction : pll_hit

    // ------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------
    logic       xin_s1_ff, xin_s2_ff, xin_d_ff;
    logic       ckin_s1_ff, ckin_s2_ff, ckin_d_ff;
    logic       sel_s1_ff, sel_s2_ff;
    logic       sd_s1_ff, sd_s2_ff;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            {xin_s1_ff, xin_s2_ff, xin_d_ff}    <= 3'h0;
            {ckin_s1_ff, ckin_s2_ff, ckin_d_ff} <= 3'h0;
            {sel_s1_ff, sel_s2_ff}              <= 2'h0;
            {sd_s1_ff, sd_s2_ff}                <= 2'h0;
        end else if (ce_i) begin
            {xin_s1_ff, xin_s2_ff, xin_d_ff}    <= {crystal_or_ref_input_i, xin_s1_ff, xin_s2_ff};
            {ckin_s1_ff, ckin_s2_ff, ckin_d_ff} <= {second_clock_input_i, ckin_s1_ff, ckin_s2_ff};
            {sel_s1_ff, sel_s2_ff}              <= {input_select_pin_i, sel_s1_ff};
            {sd_s1_ff, sd_s2_ff}                <= {shutdown_output_enable_pin_i, sd_s1_ff};
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    logic        shut_pol_ff;
    logic [7:0]  load_capacitor_field_drive_ff;
    logic [7:0]  load_cap_ff;
    logic        prim_src_ff;
    logic [1:0]  sw_mode_ff;
    logic [6:0]  div_ff  [NUM_PLL];
    logic [11:0] fb_ff   [NUM_PLL];
    logic [3:0]  frac_ff;

    wire wr_shut   = wr_i && addr_i == ADDR_SHUT_CFG;
    wire wr_drive  = wr_i && addr_i == ADDR_LOAD_CAPACITOR_FIELD_DRIVE;
    wire wr_load   = wr_i && addr_i == ADDR_LOAD_CAP;
    wire wr_switch = wr_i && addr_i == ADDR_SWITCH_CFG;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            shut_pol_ff   <= RST_SHUT_POL;
            load_capacitor_field_drive_ff <= RST_LOAD_CAPACITOR_FIELD_DRIVE;
            load_cap_ff   <= RST_LOAD_CAP;
            prim_src_ff   <= RST_PRIM_SRC;
            sw_mode_ff    <= RST_SW_MODE;
            frac_ff       <= RST_FRAC;
        end else if (ce_i) begin
            if (wr_shut) begin
                shut_pol_ff <= wdata_i[SHUT_POL_BIT];
            end
            if (wr_drive) begin
                load_capacitor_field_drive_ff <= wdata_i;
            end
            if (wr_load) begin
                load_cap_ff <= wdata_i;
            end
            if (wr_switch) begin
                prim_src_ff <= wdata_i[PRIM_SRC_BIT];
                sw_mode_ff  <= wdata_i[SW_MODE_AUTO:SW_MODE_LSB];
            end
            if (pll_hit(addr_i, 0, PLL_OFS_NHI) && wr_i) begin
                frac_ff <= wdata_i[7:4];
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PLL; gi++) begin : g_pll_regs
            localparam logic [6:0]  DIV_RST = (gi == NUM_PLL - 1) ? RST_DIV_PLL3 : RST_DIV;
            localparam logic [11:0] FB_RST  = (gi == NUM_PLL - 1) ? RST_FB_PLL3 : RST_FB;
            always_ff @(posedge core_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    div_ff[gi] <= DIV_RST;
                    fb_ff[gi]  <= FB_RST;
                end else if (ce_i && wr_i) begin
                    if (pll_hit(addr_i, gi, PLL_OFS_DIV)) begin
                        div_ff[gi] <= wdata_i[6:0];
                    end
                    if (pll_hit(addr_i, gi, PLL_OFS_NLO)) begin
                        fb_ff[gi][7:0] <= wdata_i;
                    end
                    if (pll_hit(addr_i, gi, PLL_OFS_NHI)) begin
                        fb_ff[gi][11:8] <= wdata_i[3:0];
                    end
                end
            end
            // Divider zero powers a PLL down; PLL three resets to divider 3 but takes any value 0 to 127.
            always_ff @(posedge core_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    pll_pd_o[gi]              <= 1'b0;
                    pll_mult_o[gi*14 +: 14]   <= 14'h0000;
                end else if (ce_i) begin
                    pll_pd_o[gi]              <= (div_ff[gi] == 7'h00);
                    pll_mult_o[gi*14 +: 14]   <= mult_calc(gi == 0, fb_ff[gi], frac_ff);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Absence detector and source choice
    // ------------------------------------------------------------------
    logic [1:0] miss_cnt_ff;
    logic       missing_ff;

    wire xin_tr   = xin_s2_ff ^ xin_d_ff;
    wire ckin_tr  = ckin_s2_ff ^ ckin_d_ff;
    wire prim_tr  = prim_src_ff ? ckin_tr : xin_tr;
    wire sec_rise = prim_src_ff ? (xin_s2_ff & ~xin_d_ff) : (ckin_s2_ff & ~ckin_d_ff);
    wire auto_mode = sw_mode_ff[1];
    wire auto_ok   = auto_mode && prim_src_ff == SRC_LOAD_CAPACITOR_FIELD_REF;
    wire want_sec  = auto_mode ? (auto_ok && missing_ff) : sel_s2_ff;
    wire want_src  = prim_src_ff ^ want_sec;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            miss_cnt_ff <= 2'h0;
            missing_ff  <= 1'b0;
        end else if (ce_i) begin
            if (prim_tr) begin
                miss_cnt_ff <= 2'h0;
                missing_ff  <= 1'b0;
            end else if (sec_rise && miss_cnt_ff != MISS_CYCLES) begin
                miss_cnt_ff <= miss_cnt_ff + 2'h1;
                missing_ff  <= (miss_cnt_ff + 2'h1 == MISS_CYCLES);
            end
        end
    end

    // ------------------------------------------------------------------
    // Glitch-free switch: cut the old source while low, start the new one while low
    // ------------------------------------------------------------------
    rcs_sw_e state_ff;
    logic    cur_src_ff;
    logic    ref_raw_ff;

    wire cur_val  = cur_src_ff ? ckin_s2_ff : xin_s2_ff;
    wire want_val = want_src ? ckin_s2_ff : xin_s2_ff;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff   <= RCS_RUN;
            cur_src_ff <= SRC_LOAD_CAPACITOR_FIELD_REF;
            ref_raw_ff <= 1'b0;
        end else if (ce_i) begin
            case (state_ff)
                RCS_RUN: begin
                    ref_raw_ff <= cur_val;
                    if (want_src != cur_src_ff && !cur_val) begin
                        state_ff <= RCS_DRAIN;
                    end
                end
                RCS_DRAIN: begin
                    ref_raw_ff <= 1'b0;
                    if (!want_val) begin
                        cur_src_ff <= want_src;
                        state_ff   <= RCS_RUN;
                    end
                end
                default: begin
                    state_ff <= RCS_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Shutdown and outputs
    // ------------------------------------------------------------------
    wire shut_now = (sd_s2_ff == shut_pol_ff);

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            shutdown_o <= 1'b0;
        end else if (ce_i) begin
            shutdown_o <= shut_now;
        end
    end

    assign ref_clk_o         = ref_raw_ff & ~shutdown_o;
    assign active_src_o      = cur_src_ff;
    assign primary_missing_o = missing_ff;

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    logic [7:0] rd_mux;
    logic [7:0] pll_rd;

    always_comb begin
        pll_rd = 8'h00;
        for (int i = 0; i < NUM_PLL; i++) begin
            if (pll_hit(addr_i, i, PLL_OFS_DIV)) begin
                pll_rd = {1'b0, div_ff[i]};
            end
            if (pll_hit(addr_i, i, PLL_OFS_NLO)) begin
                pll_rd = fb_ff[i][7:0];
            end
            if (pll_hit(addr_i, i, PLL_OFS_NHI)) begin
                pll_rd = {(i == 0) ? frac_ff : 4'h0, fb_ff[i][11:8]};
            end
        end
    end

    always_comb begin
        case (addr_i)
            ADDR_SHUT_CFG:   rd_mux = {7'h00, shut_pol_ff};
            ADDR_LOAD_CAPACITOR_FIELD_DRIVE: rd_mux = load_capacitor_field_drive_ff;
            ADDR_LOAD_CAP:   rd_mux = load_cap_ff;
            ADDR_SWITCH_CFG: rd_mux = {5'h00, sw_mode_ff, prim_src_ff};
            ADDR_STATUS:     rd_mux = {1'b0, pll_pd_o, shutdown_o, missing_ff, cur_src_ff};
            default:         rd_mux = pll_rd;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (ce_i) begin
            rdata_o <= rd_i ? rd_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_cut;
        ce_i && state_ff == RCS_RUN ##1 state_ff == RCS_DRAIN;
    endsequence
    property p_prim_sel;
        (ce_i && !rst_i && !auto_mode && !sel_s2_ff && state_ff == RCS_DRAIN && !want_val)
        |=> (cur_src_ff == $past(prim_src_ff));
    endproperty
    a_prim_sel: assert property (p_prim_sel) else $error("Select pin low did not land on primary.");
    property p_manual_sec;
        (ce_i && !rst_i && !auto_mode && sel_s2_ff && state_ff == RCS_DRAIN && !want_val)
        |=> (cur_src_ff != $past(prim_src_ff));
    endproperty
    a_manual_sec: assert property (p_manual_sec) else $error("Select pin high did not pick secondary.");
    property p_shut;
        (ce_i && !rst_i) |=> (shutdown_o == ($past(sd_s2_ff) == $past(shut_pol_ff)));
    endproperty
    a_shut: assert property (p_shut) else $error("Shutdown does not follow pin and polarity.");
    property p_pll_pd;
        (ce_i && !rst_i) |=> (pll_pd_o[1] == ($past(div_ff[1]) == 7'h00));
    endproperty
    a_pll_pd: assert property (p_pll_pd) else $error("PLL power down does not match zero divider.");
    property p_mult0;
        (ce_i && !rst_i) |=> (pll_mult_o[13:0] == (($past(frac_ff) != 4'h0) ?
            {1'b0, $past(fb_ff[0]), 1'b0} + {10'h000, $past(frac_ff)} + 14'h0001 : {1'b0, $past(fb_ff[0]), 1'b0}));
    endproperty
    a_mult0: assert property (p_mult0) else $error("PLL zero multiplier wrong.");
    property p_mult3;
        (ce_i && !rst_i) |=> (pll_mult_o[55:42] == {2'b00, $past(fb_ff[3])});
    endproperty
    a_mult3: assert property (p_mult3) else $error("PLL three multiplier is not the feedback value.");
    property p_switch;
        (ce_i && miss_cnt_ff == 2'h1 && sec_rise && !prim_tr) |=> missing_ff;
    endproperty
    a_switch: assert property (p_switch) else $error("Second missing cycle did not flag absence.");
    property p_cnt_clear;
        (ce_i && prim_tr) |=> (miss_cnt_ff == 2'h0 && !missing_ff);
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("Primary edge did not clear the count.");
    property p_revert;
        (ce_i && !rst_i && auto_mode && !missing_ff && cur_src_ff == prim_src_ff)
        |=> (cur_src_ff == $past(cur_src_ff));
    endproperty
    a_revert: assert property (p_revert) else $error("Automatic mode left primary while present.");
    property p_glitch;
        s_cut |=> !ref_clk_o;
    endproperty
    a_glitch: assert property (p_glitch) else $error("Reference high while switching.");

endmodule : rcs_ref_select

// ### design/rcs_pkg.sv
// Package with register map, reset values and constants of the reference clock selector.
package rcs_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_SHUT_CFG   = 8'h02;
    localparam logic [7:0] ADDR_LOAD_CAPACITOR_FIELD_DRIVE = 8'h06;
    localparam logic [7:0] ADDR_LOAD_CAP   = 8'h07;
    localparam logic [7:0] ADDR_SWITCH_CFG = 8'hBE;
    localparam logic [7:0] ADDR_STATUS     = 8'hC4;
    localparam logic [7:0] ADDR_PLL_BASE   = 8'h10;
    localparam logic [7:0] ADDR_PLL_STRIDE = 8'h04;
    localparam logic [1:0] PLL_OFS_DIV     = 2'h0;
    localparam logic [1:0] PLL_OFS_NLO     = 2'h1;
    localparam logic [1:0] PLL_OFS_NHI     = 2'h2;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int SHUT_POL_BIT   = 0;
    localparam int PRIM_SRC_BIT   = 0;
    localparam int SW_MODE_LSB    = 1;
    localparam int SW_MODE_AUTO   = 2;
    localparam int STAT_SRC_BIT   = 0;
    localparam int STAT_MISS_BIT  = 1;
    localparam int STAT_SHUT_BIT  = 2;
    localparam int STAT_PD_LSB    = 3;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic       RST_SHUT_POL   = 1'b0;
    localparam logic [7:0] RST_LOAD_CAPACITOR_FIELD_DRIVE = 8'h11;
    localparam logic [7:0] RST_LOAD_CAP   = 8'h00;
    localparam logic       RST_PRIM_SRC   = 1'b0;
    localparam logic [1:0] RST_SW_MODE    = 2'h0;
    localparam logic [6:0] RST_DIV        = 7'h01;
    localparam logic [6:0] RST_DIV_PLL3   = 7'h03;
    localparam logic [11:0] RST_FB        = 12'h001;
    localparam logic [11:0] RST_FB_PLL3   = 12'h00C;
    localparam logic [3:0] RST_FRAC       = 4'h0;

    // ------------------------------------------------------------------
    // Counts and source codes
    // ------------------------------------------------------------------
    localparam logic [1:0] MISS_CYCLES    = 2'h2;
    localparam logic       SRC_LOAD_CAPACITOR_FIELD_REF   = 1'b0;
    localparam logic       SRC_SECOND_CLK = 1'b1;
    localparam int         NUM_PLL        = 4;

    typedef enum logic {RCS_RUN, RCS_DRAIN} rcs_sw_e;

endpackage : rcs_pkg

// ### verification/rcs_ref_model.sv
// Behavioural model of the two external reference clock sources.
module rcs_ref_model #(
    parameter int PER_A = 1000,
    parameter int PER_B = 2000
) (
    input  wire logic run_a_i,
    input  wire logic run_b_i,
    output logic      clk_a_o,
    output logic      clk_b_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Both sources are oscillators, never a crystal, and a stopped source sits at its pull-down level.
    initial begin
        clk_a_o = 1'b0;
        #37;
        forever begin
            #(PER_A / 2);
            clk_a_o = run_a_i ? ~clk_a_o : 1'b0;
        end
    end
    // The second source runs slower than the first.
    initial begin
        clk_b_o = 1'b0;
        #61;
        forever begin
            #(PER_B / 2);
            clk_b_o = run_b_i ? ~clk_b_o : 1'b0;
        end
    end
endmodule : rcs_ref_model

// ### verification/reference_clock_select_switchover_tb.sv
// Self-checking testbench of the reference clock selector.
module reference_clock_select_switchover_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import rcs_pkg::*;
    logic        clk, rst, ce, run_a, run_b, sel_pin, sd_pin, wr, rd, mon_en;
    logic [7:0]  addr, wdata, rdata;
    logic        xa, xb, ref_clk, act, miss, shut;
    logic [3:0]  pd;
    logic [55:0] mult;
    int          error_cnt = 0;
    int          n_checks = 0;
    int          hi_run = 0;
    int          rises = 0;

    rcs_ref_model u_src (.run_a_i(run_a), .run_b_i(run_b), .clk_a_o(xa), .clk_b_o(xb));
    rcs_ref_select DUT (.core_clk_i(clk), .rst_i(rst), .ce_i(ce), .crystal_or_ref_input_i(xa),
        .second_clock_input_i(xb), .input_select_pin_i(sel_pin), .shutdown_output_enable_pin_i(sd_pin),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ref_clk_o(ref_clk),
        .active_src_o(act), .primary_missing_o(miss), .shutdown_o(shut), .pll_pd_o(pd), .pll_mult_o(mult));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // A high pulse of the selected reference shorter than three cycles is a glitch.
    always @(posedge clk) begin
        if (ref_clk === 1'b1) begin
            if (hi_run == 0) rises++;
            hi_run <= hi_run + 1;
        end else begin
            if (mon_en && hi_run > 0 && hi_run < 3) begin
                error_cnt++;
                $display("CHECK FAILED at %0t: short pulse on selected reference", $time);
            end
            hi_run <= 0;
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [13:0] got, input logic [13:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        repeat (2) @(negedge clk);
        @(posedge clk);
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk({6'h00, rdata}, {6'h00, exp}, what);
        @(posedge clk);
    endtask : rd_chk

    // Waits a bounded number of cycles for a level on an output, then compares it.
    task automatic wait_lvl(input int which, input logic exp, input int max_cyc, input string what);
        logic v;
        for (int i = 0; i < max_cyc; i++) begin
            @(negedge clk);
            v = (which == 0) ? act : (which == 1) ? miss : shut;
            if (v === exp) break;
        end
        chk({13'h0000, v}, {13'h0000, exp}, what);
        @(posedge clk);
    endtask : wait_lvl

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        repeat (2) @(negedge clk);
        chk(mult[13:0], 14'h0002, "pll0 mult");
        chk(mult[27:14], 14'h0001, "pll1 mult");
        chk(mult[41:28], 14'h0001, "pll2 mult");
        chk(mult[55:42], 14'h000C, "pll3 mult");
        chk({10'h000, pd}, 14'h0000, "power down");
        rd_chk(ADDR_SHUT_CFG, 8'h00, "polarity");
        rd_chk(ADDR_LOAD_CAPACITOR_FIELD_DRIVE, 8'h11, "drive strength");
        rd_chk(ADDR_LOAD_CAP, 8'h00, "load cap");
        rd_chk(ADDR_SWITCH_CFG, 8'h00, "switch cfg");
        rd_chk(8'h50, 8'h00, "unmapped");
        ce <= 1'b0;
        wr_reg(ADDR_LOAD_CAP, 8'h1F);
        ce <= 1'b1;
        rd_chk(ADDR_LOAD_CAP, 8'h00, "write while frozen");
        $display("test reset done");
    endtask : t_reset

    task automatic t_pll();
        logic [7:0] a;
        wr_reg(ADDR_PLL_BASE + 8'h01, 8'h05);
        wr_reg(ADDR_PLL_BASE + 8'h02, 8'h30);
        chk(mult[13:0], 14'h000E, "pll0 n5 a3");
        wr_reg(ADDR_PLL_BASE + 8'h02, 8'h00);
        chk(mult[13:0], 14'h000A, "pll0 n5 a0");
        wr_reg(ADDR_PLL_BASE + 8'h01, 8'hFF);
        wr_reg(ADDR_PLL_BASE + 8'h02, 8'hFF);
        chk(mult[13:0], 14'h200E, "pll0 max");
        wr_reg(8'h19, 8'hFF);
        wr_reg(8'h1A, 8'h0F);
        chk(mult[41:28], 14'h0FFF, "pll2 max");
        for (int i = 0; i < 3; i++) begin
            a = ADDR_PLL_BASE + ADDR_PLL_STRIDE * 8'(i);
            wr_reg(a, 8'h00);
            chk({13'h0000, pd[i]}, 14'h0001, "divider zero");
            wr_reg(a, 8'h7F);
            chk({13'h0000, pd[i]}, 14'h0000, "divider 127");
        end
        wr_reg(8'h1C, 8'h03);
        chk({10'h000, pd}, 14'h0000, "pll3 divider 3");
        $display("test pll done");
    endtask : t_pll

    task automatic t_shutdown();
        wait_lvl(2, 1'b0, 4, "pin high idle");
        sd_pin <= 1'b0;
        wait_lvl(2, 1'b1, 8, "active low shutdown");
        rd_chk(ADDR_STATUS, 8'h04, "status shutdown");
        sd_pin <= 1'b1;
        wait_lvl(2, 1'b0, 8, "active low release");
        wr_reg(ADDR_SHUT_CFG, 8'h01);
        wait_lvl(2, 1'b1, 8, "active high shutdown");
        sd_pin <= 1'b0;
        wait_lvl(2, 1'b0, 8, "active high release");
        $display("test shutdown done");
    endtask : t_shutdown

    task automatic t_manual();
        mon_en = 1'b1;
        wait_lvl(0, 1'b0, 4, "primary first input");
        sel_pin <= 1'b1;
        wait_lvl(0, 1'b1, 60, "manual to secondary");
        @(negedge clk);
        rises = 0;
        repeat (60) @(negedge clk);
        chk({13'h0000, rises > 2}, 14'h0001, "secondary passed");
        wr_reg(ADDR_SWITCH_CFG, 8'h03);
        wait_lvl(0, 1'b0, 60, "second primary, pin secondary");
        sel_pin <= 1'b0;
        wait_lvl(0, 1'b1, 60, "second input primary");
        wr_reg(ADDR_SWITCH_CFG, 8'h00);
        wait_lvl(0, 1'b0, 60, "back to first input");
        mon_en = 1'b0;
        $display("test manual done");
    endtask : t_manual

    task automatic t_auto();
        int hits;
        hits = 0;
        wr_reg(ADDR_SWITCH_CFG, 8'h04);
        sel_pin <= 1'b1;
        repeat (40) @(negedge clk);
        chk({13'h0000, act}, 14'h0000, "auto ignores pin");
        run_a <= 1'b0;
        repeat (10) @(posedge clk);
        run_a <= 1'b1;
        for (int i = 0; i < 30; i++) begin
            @(negedge clk);
            if (miss !== 1'b0) hits++;
        end
        chk(14'(hits), 14'h0000, "short gap no alarm");
        run_a <= 1'b0;
        wait_lvl(1, 1'b1, 80, "primary missing");
        wait_lvl(0, 1'b1, 30, "failover");
        run_a <= 1'b1;
        wait_lvl(1, 1'b0, 20, "primary back");
        wait_lvl(0, 1'b0, 40, "revert");
        sel_pin <= 1'b0;
        $display("test auto done");
    endtask : t_auto

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        run_a = 1'b1;
        run_b = 1'b1;
        sel_pin = 1'b0;
        sd_pin = 1'b1;
        mon_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_pll();
        t_shutdown();
        t_manual();
        t_auto();
        report_and_stop();
    end

    initial begin
        repeat (6000) @(posedge clk);
        error_cnt++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule : reference_clock_select_switchover_tb
